// ==== verilog/uart_psave_pkg.sv ====
package uart_psave_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIMEOUT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // CTRL fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FLOW_BIT = 2;
  localparam int CTRL_AUTOBAUD_BIT = 3;
  localparam int CTRL_TRB_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  // power_save_mode_setting values
  localparam logic [1:0] MODE_FIXED = 2'h0;
  localparam logic [1:0] MODE_CYCLIC = 2'h1;
  localparam logic [1:0] MODE_RTS = 2'h2;
  localparam logic [1:0] MODE_DTR = 2'h3;

  // Idle timeout in radio frames
  localparam logic [15:0] TIMEOUT_MIN = 16'h0028;
  localparam logic [15:0] TIMEOUT_MAX = 16'hFDE8;
  localparam logic [15:0] TIMEOUT_RESET = 16'h07D0;

  // STATUS fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_UART_EN_BIT = 2;
  localparam int ST_IDLE_BIT = 3;
  localparam int ST_RTS_BIT = 4;
  localparam int ST_DTR_BIT = 5;
  localparam int ST_USB_BIT = 6;
  localparam int ST_ARMED_BIT = 7;

  // Timing
  localparam real CLK_PERIOD_NS = 100.0;
  localparam real FRAME_TIME_MS = 4.615;
  localparam real WAKE_TIME_MS = 20.0;
  localparam int FRAME_CYCLES = int'(FRAME_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int WAKE_CYCLES = int'(WAKE_TIME_MS * 1.0e6 / CLK_PERIOD_NS);

  // Port power state
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAKE = 2'b01,
    ST_ON = 2'b10
  } port_state_t;

endpackage

// ==== verilog/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes state while low
  input wire logic [WIDTH-1:0] pin_in, // Raw asynchronous pins
  output logic [WIDTH-1:0] level // Filtered level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // Accept a change only when the second and third stages agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  // Stage one feeds only stage two, to bound metastability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level <= RESET_VAL;
    end else if (clk_en) begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ==== verilog/uart_power_save_wake.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_power_save_wake #(
  parameter int FRAME_CYCLES = uart_psave_pkg::FRAME_CYCLES,
  parameter int WAKE_CYCLES = uart_psave_pkg::WAKE_CYCLES
) (
  input wire logic pclk, // System clock, 10 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic rts_n, // Host request-to-send pin, ON low
  input wire logic dtr_n, // Host terminal-ready pin, ON low
  input wire logic rxd, // Receive data pin, idle high
  input wire logic rx_char_valid, // Receiver got a character
  input wire logic tx_pending, // Device has output to send
  input wire logic network_activity, // Radio needs the device
  input wire logic internal_activity, // Other function is busy
  input wire logic usb_attached, // USB bus present
  input wire logic usb_suspended, // USB in suspend
  output logic cts_n, // Clear-to-send pin, ON low
  output logic uart_enable, // Serial port powered
  output logic rx_accept, // Received characters are valid
  output logic low_power_idle, // Device may sleep
  output logic usb_ready, // USB kept ready
  output logic dtr_event, // Terminal-ready line changed
  output logic [1:0] term_ready_behavior // Behaviour for that change
);

  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  localparam int FRAME_W = $clog2(FRAME_CYCLES + 1);
  localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES - 1);
  localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_CYCLES - 1);

  // Configuration and state
  logic [1:0] mode;
  logic flow_ctrl_en;
  logic autobaud_en;
  logic [1:0] trb;
  logic [15:0] idle_timeout;
  uart_psave_pkg::port_state_t state;
  logic [WAKE_W-1:0] wake_cnt;
  logic [FRAME_W-1:0] frame_cnt;
  logic [15:0] idle_cnt;
  logic dtr_prev, rxd_prev;
  logic [2:0] pins_level;

  logic [1:0] next_mode;
  logic next_flow_ctrl_en, next_autobaud_en;
  logic [1:0] next_trb;
  logic [15:0] next_idle_timeout;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  uart_psave_pkg::port_state_t next_state;
  logic [WAKE_W-1:0] next_wake_cnt;
  logic [FRAME_W-1:0] next_frame_cnt;
  logic [15:0] next_idle_cnt;
  logic next_cts_n, next_uart_enable, next_rx_accept;
  logic next_low_power_idle, next_usb_ready, next_dtr_event;

  logic rts_on, dtr_on, rxd_lvl, rxd_rise, wake_armed, line_on;
  logic acc_phase, bad_access, status_read;
  logic [31:0] ctrl_word, status_word;

  // Pins from the host are asynchronous; rxd idles high
  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h7)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pin_in({rxd, dtr_n, rts_n}),
    .level(pins_level)
  );

  // Decoded line states
  assign rts_on = ~pins_level[0];
  assign dtr_on = ~pins_level[1];
  assign rxd_lvl = pins_level[2];
  assign rxd_rise = rxd_lvl & ~rxd_prev;
  // The autobaud bit does not gate this term; only mode and flow gate it
  assign wake_armed = (mode == uart_psave_pkg::MODE_CYCLIC) &
                      ~flow_ctrl_en;
  assign line_on = ((mode == uart_psave_pkg::MODE_RTS) & rts_on) |
                   ((mode == uart_psave_pkg::MODE_DTR) & dtr_on);

  assign ctrl_word = {26'h0, trb, autobaud_en, flow_ctrl_en, mode};
  assign status_word = {24'h0, wake_armed, usb_ready, dtr_on, rts_on,
                        low_power_idle, uart_enable, state};
  assign acc_phase = psel & penable;
  assign status_read = paddr == uart_psave_pkg::STATUS_OFS;

  // Refused writes: RTS mode with flow control, timeout out of range, any STATUS write; unmapped offsets refuse reads and writes
  always_comb begin
    bad_access = 1'b0;
    case (paddr)
      uart_psave_pkg::CTRL_OFS: begin
        if (pwrite && pwdata[uart_psave_pkg::CTRL_FLOW_BIT] &&
            pwdata[uart_psave_pkg::CTRL_MODE_LSB +: 2] ==
            uart_psave_pkg::MODE_RTS) begin
          bad_access = 1'b1;
        end
      end
      uart_psave_pkg::TIMEOUT_OFS: begin
        if (pwrite && (pwdata[15:0] < uart_psave_pkg::TIMEOUT_MIN ||
            pwdata[15:0] > uart_psave_pkg::TIMEOUT_MAX)) begin
          bad_access = 1'b1;
        end
      end
      uart_psave_pkg::STATUS_OFS: begin
        bad_access = pwrite;
      end
      default: begin
        bad_access = 1'b1;
      end
    endcase
  end

  // APB slave: one wait state so read data come from a flop
  always_comb begin
    next_pready = acc_phase & ~pready;
    next_pslverr = acc_phase & ~pready & bad_access;
    next_prdata = 32'h00000000;
    next_mode = mode;
    next_flow_ctrl_en = flow_ctrl_en;
    next_autobaud_en = autobaud_en;
    next_trb = trb;
    next_idle_timeout = idle_timeout;
    if (acc_phase && !pready && !pwrite && !bad_access) begin
      if (paddr == uart_psave_pkg::CTRL_OFS) begin
        next_prdata = ctrl_word;
      end else if (paddr == uart_psave_pkg::TIMEOUT_OFS) begin
        next_prdata = {16'h0, idle_timeout};
      end else if (status_read) begin
        next_prdata = status_word;
      end
    end
    // Writes land only at the edge that sees pready high
    if (acc_phase && pready && pwrite && !pslverr) begin
      if (paddr == uart_psave_pkg::CTRL_OFS) begin
        // DTR mode is taken with flow control on or off
        next_mode = pwdata[uart_psave_pkg::CTRL_MODE_LSB +: 2];
        next_flow_ctrl_en = pwdata[uart_psave_pkg::CTRL_FLOW_BIT];
        next_autobaud_en = pwdata[uart_psave_pkg::CTRL_AUTOBAUD_BIT];
        next_trb = pwdata[uart_psave_pkg::CTRL_TRB_LSB +: 2];
      end else if (paddr == uart_psave_pkg::TIMEOUT_OFS) begin
        next_idle_timeout = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode <= uart_psave_pkg::CTRL_RESET[1:0];
      flow_ctrl_en <= uart_psave_pkg::CTRL_RESET[2];
      autobaud_en <= uart_psave_pkg::CTRL_RESET[3];
      trb <= uart_psave_pkg::CTRL_RESET[5:4];
      idle_timeout <= uart_psave_pkg::TIMEOUT_RESET;
    end else if (clk_en) begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      mode <= next_mode;
      flow_ctrl_en <= next_flow_ctrl_en;
      autobaud_en <= next_autobaud_en;
      trb <= next_trb;
      idle_timeout <= next_idle_timeout;
    end
  end

  // Port power sequencer
  always_comb begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    next_frame_cnt = frame_cnt;
    next_idle_cnt = idle_cnt;
    case (state)
      uart_psave_pkg::ST_OFF: begin
        next_frame_cnt = '0;
        next_idle_cnt = idle_timeout;
        if (mode == uart_psave_pkg::MODE_FIXED) begin
          next_state = uart_psave_pkg::ST_ON;
        end else if (line_on || (wake_armed && rxd_rise) ||
                     ((mode == uart_psave_pkg::MODE_CYCLIC) &&
                      network_activity)) begin
          // The waking character itself is never accepted
          next_state = uart_psave_pkg::ST_WAKE;
          next_wake_cnt = WAKE_LOAD;
        end
      end
      uart_psave_pkg::ST_WAKE: begin
        if (mode == uart_psave_pkg::MODE_FIXED) begin
          next_state = uart_psave_pkg::ST_ON;
        end else if (mode != uart_psave_pkg::MODE_CYCLIC && !line_on) begin
          next_state = uart_psave_pkg::ST_OFF;
        end else if (wake_cnt == '0) begin
          next_state = uart_psave_pkg::ST_ON;
        end else begin
          next_wake_cnt = wake_cnt - 1'b1;
        end
      end
      uart_psave_pkg::ST_ON: begin
        if (mode == uart_psave_pkg::MODE_CYCLIC) begin
          next_frame_cnt = (frame_cnt == FRAME_LAST) ? '0 :
                           frame_cnt + 1'b1;
          if (rx_char_valid || network_activity) begin
            // Every character restarts the whole timeout
            next_frame_cnt = '0;
            next_idle_cnt = idle_timeout;
          end else if (frame_cnt == FRAME_LAST) begin
            if (idle_cnt <= 16'h0001) begin
              next_state = uart_psave_pkg::ST_OFF;
            end else begin
              next_idle_cnt = idle_cnt - 1'b1;
            end
          end
        end else begin
          next_frame_cnt = '0;
          next_idle_cnt = idle_timeout;
          if (mode != uart_psave_pkg::MODE_FIXED && !line_on) begin
            next_state = uart_psave_pkg::ST_OFF;
          end
        end
      end
      default: begin
        next_state = uart_psave_pkg::ST_OFF;
      end
    endcase
  end

  // Registered pin and status outputs follow the next state
  always_comb begin
    next_rx_accept = next_state == uart_psave_pkg::ST_ON;
    next_cts_n = ~next_rx_accept;
    // Output traffic borrows the port without waking reception
    next_uart_enable = next_rx_accept | tx_pending;
    next_usb_ready = usb_attached & ~usb_suspended;
    // Sleep needs power saving on and nothing at all asking for work
    next_low_power_idle = (mode != uart_psave_pkg::MODE_FIXED) &&
                          (next_state == uart_psave_pkg::ST_OFF) &&
                          !tx_pending && !network_activity &&
                          !internal_activity && !next_usb_ready;
    next_dtr_event = dtr_on ^ dtr_prev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= uart_psave_pkg::ST_OFF;
      wake_cnt <= '0;
      frame_cnt <= '0;
      idle_cnt <= uart_psave_pkg::TIMEOUT_RESET;
      dtr_prev <= 1'b0;
      rxd_prev <= 1'b1;
      cts_n <= 1'b1;
      uart_enable <= 1'b0;
      rx_accept <= 1'b0;
      low_power_idle <= 1'b0;
      usb_ready <= 1'b0;
      dtr_event <= 1'b0;
      term_ready_behavior <= 2'h0;
    end else if (clk_en) begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      frame_cnt <= next_frame_cnt;
      idle_cnt <= next_idle_cnt;
      dtr_prev <= dtr_on;
      rxd_prev <= rxd_lvl;
      cts_n <= next_cts_n;
      uart_enable <= next_uart_enable;
      rx_accept <= next_rx_accept;
      low_power_idle <= next_low_power_idle;
      usb_ready <= next_usb_ready;
      dtr_event <= next_dtr_event;
      term_ready_behavior <= trb;
    end
  end

endmodule // uart_power_save_wake

`default_nettype wire

// ==== tb/uart_psave_chk_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_psave_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic clk_en, // Run
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic tx_pending, // Output due
  input wire logic usb_attached, // USB in
  input wire logic usb_suspended, // USB asleep
  input wire logic cts_n, // Clear-to-send
  input wire logic uart_enable, // Port on
  input wire logic rx_accept, // Data valid
  input wire logic low_power_idle, // Sleep
  input wire logic usb_ready, // USB ready
  input wire logic dtr_event // Line pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Pin and power relations
  a_cts_accept: assert property (cts_n != rx_accept)
    else $error("cts_n does not mirror rx_accept");
  a_usb_follow: assert property (clk_en |=>
    usb_ready == $past(usb_attached && !usb_suspended))
    else $error("usb_ready wrong");
  a_tx_enable: assert property (clk_en && tx_pending |=> uart_enable)
    else $error("port not on for output");
  a_accept_port: assert property (rx_accept |-> uart_enable)
    else $error("data accepted with port off");
  a_idle_quiet: assert property (low_power_idle |->
    !rx_accept && !usb_ready)
    else $error("idle while active");
  a_dtr_pulse: assert property (dtr_event |=> !dtr_event)
    else $error("dtr_event too long");

  // Register bus answers after one wait state, errors only with ready
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready timing wrong");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  c_wake: cover property ($rose(rx_accept));
  c_idle: cover property ($rose(low_power_idle));
  c_err: cover property (pslverr);
endmodule // uart_psave_chk

bind uart_power_save_wake uart_psave_chk uart_psave_chk_i (.pclk, .presetn,
  .clk_en, .psel, .penable, .pready, .pslverr, .tx_pending, .usb_attached,
  .usb_suspended, .cts_n, .uart_enable, .rx_accept, .low_power_idle,
  .usb_ready, .dtr_event);

`default_nettype wire

// ==== tb/host_term.sv ====
`timescale 1ns/1ps
`default_nettype none

module host_term #(
  parameter int BIT_CYCLES = 2
) (
  input wire logic pclk, // Clock
  output logic rts_n, // Request-to-send
  output logic dtr_n, // Terminal-ready
  output logic rxd // Data toward device
);
  // Both lines ON, data line idles high like its pull-up
  initial begin
    rts_n = 1'b0;
    dtr_n = 1'b0;
    rxd = 1'b1;
  end

  // Mode 2 is asked for by the bench with flow control off and, refused, with it on
  task automatic set_lines(input logic r, input logic d);
    rts_n <= r;
    dtr_n <= d;
    @(posedge pclk);
  endtask

  // Start low, LSB first, stop high; a dummy first char serves as wake
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] f;
    f = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
  endtask
endmodule // host_term

`default_nettype wire

// ==== tb/uart_power_save_wake_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_power_save_wake_tb;
  localparam int WAKE = 20;
  localparam logic [7:0] A_CTRL = uart_psave_pkg::CTRL_OFS;
  localparam logic [7:0] A_TMO = uart_psave_pkg::TIMEOUT_OFS;
  localparam logic [7:0] A_STAT = uart_psave_pkg::STATUS_OFS;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rts_n, dtr_n, rxd, rx_char_valid, tx_pending, network_activity;
  logic internal_activity, usb_attached, usb_suspended, cts_n, uart_enable;
  logic rx_accept, low_power_idle, usb_ready, dtr_event;
  logic [1:0] term_ready_behavior;
  int bad_count, samples_checked, n;

  // Short frame and wake counts keep the run brief
  uart_power_save_wake #(.FRAME_CYCLES(10), .WAKE_CYCLES(WAKE))
    uart_power_save_wake_i (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rts_n, .dtr_n,
    .rxd, .rx_char_valid, .tx_pending, .network_activity,
    .internal_activity, .usb_attached, .usb_suspended, .cts_n, .uart_enable,
    .rx_accept, .low_power_idle, .usb_ready, .dtr_event,
    .term_ready_behavior);
  host_term #(.BIT_CYCLES(2)) host_term_i (.pclk, .rts_n, .dtr_n, .rxd);

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic results();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Range compare, for delays that are only approximate
  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo,
    input logic [31:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  // Count edges until an output reaches v; a hang ends the run
  task automatic wait_on(input int s, input logic v);
    logic cur;
    n = 0;
    cur = ~v;
    while (cur !== v) begin
      @(posedge pclk);
      n++;
      cur = s == 0 ? cts_n : s == 1 ? rx_accept : s == 2 ? low_power_idle
        : dtr_event;
      if (n > 3000) begin
        bad_count++;
        results();
      end
    end
  endtask

  // Request held until pready is sampled; an idle edge follows so that
  // psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_defaults();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, uart_psave_pkg::CTRL_RESET);
    apb(1'b0, A_TMO, 32'h0);
    chk(rd, {16'h0, uart_psave_pkg::TIMEOUT_RESET});
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h36);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    chk(cts_n, 1'b0);
  endtask

  task automatic t_refuse();
    logic [7:0] ad [8];
    logic [31:0] dt [8];
    logic ex [8];
    ad = '{A_CTRL, A_CTRL, A_CTRL, A_STAT, A_TMO, A_TMO, A_TMO, A_TMO};
    dt = '{32'h6, 32'h2, 32'h6, 32'h0, 32'h27, 32'h28, 32'hFDE9, 32'hFDE8};
    ex = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    foreach (ad[i]) begin
      apb(1'b1, ad[i], dt[i]);
      chk(err, ex[i]);
    end
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, A_TMO, 32'h0);
    chk(rd, 32'hFDE8);
  endtask

  task automatic t_rts();
    host_term_i.set_lines(1'b1, 1'b0);
    wait_on(0, 1'b1);
    chk_in(n, 3, 8);
    chk(low_power_idle, 1'b1);
    tx_pending <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(uart_enable, 1'b1);
    tx_pending <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(uart_enable, 1'b0);
    host_term_i.set_lines(1'b0, 1'b0);
    wait_on(1, 1'b1);
    chk_in(n, WAKE, WAKE + 10);
    chk(low_power_idle, 1'b0);
  endtask

  task automatic t_dtr();
    apb(1'b1, A_CTRL, 32'h27);
    chk(err, 1'b0);
    // The behaviour field reaches its pins one edge after the write
    @(posedge pclk);
    chk(term_ready_behavior, 2'h2);
    host_term_i.set_lines(1'b0, 1'b1);
    wait_on(3, 1'b1);
    chk_in(n, 2, 8);
    wait_on(0, 1'b1);
    chk_in(n, 0, 4);
    host_term_i.set_lines(1'b0, 1'b0);
    wait_on(1, 1'b1);
    chk_in(n, WAKE, WAKE + 10);
    chk(cts_n, 1'b0);
  endtask

  // Cyclic mode: a reload, timeout, data wake, then an unarmed data line
  task automatic t_cyclic();
    apb(1'b1, A_TMO, 32'h28);
    // Autobaud bit stays clear in every mode write
    apb(1'b1, A_CTRL, 32'h1);
    repeat (300) @(posedge pclk);
    rx_char_valid <= 1'b1;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    wait_on(0, 1'b1);
    chk_in(n, 385, 415);
    wait_on(2, 1'b1);
    chk_in(n, 0, 3);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'hB8);
    fork
      host_term_i.send_char(8'h41);
      wait_on(1, 1'b1);
    join
    chk_in(n, WAKE + 2, WAKE + 12);
    apb(1'b1, A_CTRL, 32'h5);
    wait_on(0, 1'b1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h38);
    host_term_i.send_char(8'h41);
    repeat (40) @(posedge pclk);
    chk(rx_accept, 1'b0);
    // Any busy internal function keeps the device out of sleep
    internal_activity <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(low_power_idle, 1'b0);
    internal_activity <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(low_power_idle, 1'b1);
    network_activity <= 1'b1;
    @(posedge pclk);
    network_activity <= 1'b0;
    wait_on(1, 1'b1);
    chk_in(n, WAKE - 1, WAKE + 6);
  endtask

  task automatic t_usb();
    usb_attached <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(usb_ready, 1'b1);
    usb_suspended <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(usb_ready, 1'b0);
    // A low clock enable must hold every output where it stands
    clk_en <= 1'b0;
    usb_suspended <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(usb_ready, 1'b0);
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(usb_ready, 1'b1);
  endtask

  // Inputs set at time zero, reset for 8 cycles, then the scenarios
  initial begin
    bad_count = 0;
    samples_checked = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_char_valid, tx_pending, network_activity} = '0;
    {internal_activity, usb_attached, usb_suspended} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults();
    t_refuse();
    t_rts();
    t_dtr();
    t_cyclic();
    t_usb();
    results();
  end
endmodule // uart_power_save_wake_tb

`default_nettype wire
